// ===== hdl/mccs_link_fsm.v
// Link state machine: Ready, Started, Connecting, Run
`timescale 1ns/100ps
module mccs_link_fsm (
    // Clock and reset
    input  wire       clk_i,
    input  wire       rst_b_i,
    // Control
    input  wire       enable_i,
    input  wire       start_i,
    input  wire       auto_i,
    // Link events
    input  wire       null_rx_i,
    input  wire       fct_rx_i,
    input  wire       err_i,
    // State
    output wire       started_o,
    output wire       run_o
);
    localparam [3:0] ST_READY = 4'h1;
    localparam [3:0] ST_START = 4'h2;
    localparam [3:0] ST_CONN  = 4'h4;
    localparam [3:0] ST_RUN   = 4'h8;

    reg [3:0] state_ff;
    reg [3:0] nxt_state;

    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_READY: begin
                // Auto-start waits for the far end's Null
                if (enable_i && (start_i || (auto_i && null_rx_i))) begin
                    nxt_state = ST_START;
                end
            end
            ST_START: begin
                if (null_rx_i) begin
                    nxt_state = ST_CONN;
                end
            end
            ST_CONN: begin
                if (fct_rx_i) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                nxt_state = ST_RUN;
            end
            default: begin
                nxt_state = ST_READY;
            end
        endcase
        // Start bit is not looked at again once Ready is left
        if (err_i || !enable_i) begin
            nxt_state = ST_READY;
        end
    end

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_ff <= ST_READY;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign started_o = (state_ff != ST_READY);
    assign run_o     = (state_ff == ST_RUN);
endmodule

// ===== hdl/mccs_plen.v
// Packet-length read path with valid-lengths-only option
`timescale 1ns/100ps
`include "mccs_regs.vh"
module mccs_plen (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_b_i,
    // Control
    input  wire        valid_only_i,
    input  wire        rd_i,
    // Length FIFO side
    input  wire [31:0] fifo_data_i,
    input  wire        fifo_empty_i,
    output wire        fifo_pop_o,
    // Result
    output wire [31:0] len_o
);
    reg [31:0] last_ff;
    reg [31:0] len_ff;

    assign fifo_pop_o = rd_i & ~fifo_empty_i;

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            last_ff <= `MCCS_ZERO32;
            len_ff  <= `MCCS_ZERO32;
        end else if (rd_i) begin
            if (!fifo_empty_i) begin
                last_ff <= fifo_data_i;
                len_ff  <= fifo_data_i;
            end else if (valid_only_i) begin
                len_ff  <= `MCCS_ZERO32;
            end else begin
                len_ff  <= last_ff;
            end
        end
    end

    assign len_o = len_ff;
endmodule

// ===== hdl/mccs_regs.vh
// Offsets, field positions and reset values of the channel control/status block
`ifndef MCCS_REGS_VH
`define MCCS_REGS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define MCCS_OFS_CTRL      8'h00
`define MCCS_OFS_STAT      8'h04
`define MCCS_ADDR_W        8

// ----------------------------------------------------------------------
// Control word
// ----------------------------------------------------------------------
`define MCCS_CTRL_RST      32'h0000_0000
`define MCCS_CTRL_WMASK    32'h06ab_77f0
`define MCCS_C_DMA_RDY     31
`define MCCS_C_TCF_HI      29
`define MCCS_C_TCF_LO      28
`define MCCS_C_PCG_IE      26
`define MCCS_C_VLO         25
`define MCCS_C_LVL_LD      23
`define MCCS_C_ARB_PRI     21
`define MCCS_C_DMA_IE      19
`define MCCS_C_FORCE       17
`define MCCS_C_MIE         16
`define MCCS_C_PKT_IE      14
`define MCCS_C_RXE_IE      13
`define MCCS_C_AF_IE       12
`define MCCS_C_PKT_DIS     10
`define MCCS_C_AUTO        9
`define MCCS_C_START       8
`define MCCS_C_LNK_EN      7
`define MCCS_C_LOOP        6
`define MCCS_C_RX_RST      5
`define MCCS_C_TX_RST      4

// ----------------------------------------------------------------------
// Status word
// ----------------------------------------------------------------------
`define MCCS_STAT_RST      32'h0000_0000
`define MCCS_STAT_W1C      32'hc00f_4000
`define MCCS_S_LAF         31
`define MCCS_S_LAE         30
`define MCCS_S_TC_HI       29
`define MCCS_S_TC_LO       24
`define MCCS_S_IRQ         23
`define MCCS_S_PLV         22
`define MCCS_S_LINK        20
`define MCCS_S_RD_ERR      19
`define MCCS_S_WR_ERR      18
`define MCCS_S_RD_DONE     17
`define MCCS_S_WR_DONE     16
`define MCCS_S_PCG         15
`define MCCS_S_PKT         14
`define MCCS_S_ERR_HI      13
`define MCCS_S_ERR_LO      8
`define MCCS_S_RDV         7
`define MCCS_S_RXF         6
`define MCCS_S_RXAF        5
`define MCCS_S_RXE         4
`define MCCS_S_TXE_HI      3
`define MCCS_S_TXF         2
`define MCCS_S_TXAE        1
`define MCCS_S_TXE         0

// ----------------------------------------------------------------------
// Widths and codes
// ----------------------------------------------------------------------
`define MCCS_LVL_W         16
`define MCCS_TC_W          6
`define MCCS_MON_OFF       2'h0
`define MCCS_ZERO32        32'h0000_0000

`endif

// ===== hdl/mccs_top.v
// Channel control and status registers of one monitor channel
`timescale 1ns/100ps
`include "mccs_regs.vh"
module mccs_top (
    // Clock and reset
    input  wire        MCLK_I,
    input  wire        RST_B_I,
    // Register port
    input  wire [7:0]  REG_ADDR_I,
    input  wire        REG_WR_I,
    input  wire        REG_RD_I,
    input  wire [31:0] REG_WDATA_I,
    output wire [31:0] REG_RDATA_O,
    // DMA engine
    input  wire        RD_DMA_BUSY_I,
    input  wire        RD_DMA_DONE_I,
    input  wire        WR_DMA_DONE_I,
    input  wire        RD_DMA_ERR_I,
    input  wire        WR_DMA_ERR_I,
    output wire        DMA_PRIO_REQ_O,
    // FIFO levels and flags
    input  wire [15:0] RX_LEVEL_I,
    input  wire [15:0] RX_AFL_I,
    input  wire [15:0] TX_LEVEL_I,
    input  wire [15:0] TX_AEL_I,
    input  wire        RX_DATA_VALID_I,
    input  wire        RX_FULL_I,
    input  wire        RX_EMPTY_I,
    input  wire        TX_FULL_I,
    input  wire        TX_EMPTY_I,
    // Packet accounting
    input  wire        PKT_RCVD_I,
    input  wire [15:0] PKT_CNT_I,
    input  wire [15:0] PKT_THR_I,
    input  wire        PLEN_RD_I,
    input  wire [31:0] PLEN_FIFO_DATA_I,
    input  wire        PLEN_FIFO_EMPTY_I,
    output wire        PLEN_POP_O,
    output wire [31:0] PLEN_DATA_O,
    // Transmit path
    input  wire        TX_WR_I,
    input  wire [31:0] TX_WDATA_I,
    input  wire        TX_LEN_AVAIL_I,
    output wire        TX_GO_O,
    output wire        EOP_EN_O,
    output wire        RX_LB_WR_O,
    output wire [31:0] RX_LB_WDATA_O,
    output wire        LVL_ACCESS_O,
    // Link
    input  wire [1:0]  MON_MODE_I,
    input  wire        NULL_RX_I,
    input  wire        FCT_RX_I,
    input  wire        LINK_ERR_I,
    input  wire [5:0]  TIME_CODE_I,
    output wire        LINK_STARTED_O,
    // Resets
    output wire        TX_RST_O,
    output wire        RX_RST_O,
    output wire        DDR_CNT_CLR_O,
    output wire        PROT_RST_O,
    // Interrupt
    output wire        IRQ_O
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function ge16;
        input [`MCCS_LVL_W-1:0] a;
        input [`MCCS_LVL_W-1:0] b;
        begin
            ge16 = (a >= b);
        end
    endfunction

    function hit;
        input [`MCCS_ADDR_W-1:0] addr;
        input [`MCCS_ADDR_W-1:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    reg  [31:0] ctrl_ff;
    reg  [31:0] lat_ff;
    reg  [31:0] nxt_lat;
    reg  [31:0] rdata_ff;
    reg  [31:0] nxt_rdata;
    reg  [31:0] lb_data_ff;
    reg         lb_wr_ff;
    reg         pkt_valid_ff;
    reg  [31:0] stat_word;
    reg  [31:0] lat_set;
    reg  [31:0] lat_clr;
    wire        wr_ctrl;
    wire        wr_stat;
    wire        rx_af_now;
    wire        rx_af_over;
    wire        tx_ae_now;
    wire        pcg_flag;
    wire        link_en;
    wire        link_run;
    wire        irq_nondma;
    wire        irq_dma;
    wire        tx_data_avail;
    wire        plen_pop;

    assign wr_ctrl = REG_WR_I & hit(REG_ADDR_I, `MCCS_OFS_CTRL);
    assign wr_stat = REG_WR_I & hit(REG_ADDR_I, `MCCS_OFS_STAT);

    // ------------------------------------------------------------------
    // Control word
    // ------------------------------------------------------------------
    // Read-only and spare bits are masked so they never store
    always @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            ctrl_ff <= `MCCS_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_ff <= REG_WDATA_I & `MCCS_CTRL_WMASK;
        end
    end

    // ------------------------------------------------------------------
    // Level comparisons
    // ------------------------------------------------------------------
    assign rx_af_now  = ge16(RX_LEVEL_I, RX_AFL_I);
    // Latched flag uses strictly above, the live flag at or above
    assign rx_af_over = ~ge16(RX_AFL_I, RX_LEVEL_I);
    assign tx_ae_now  = ~ge16(TX_LEVEL_I, TX_AEL_I);
    assign pcg_flag   = ~ge16(PKT_THR_I, PKT_CNT_I);

    // ------------------------------------------------------------------
    // Latched status
    // ------------------------------------------------------------------
    always @* begin
        lat_set = `MCCS_ZERO32;
        lat_set[`MCCS_S_LAF]     = rx_af_over;
        lat_set[`MCCS_S_LAE]     = tx_ae_now;
        lat_set[`MCCS_S_RD_ERR]  = RD_DMA_ERR_I;
        lat_set[`MCCS_S_WR_ERR]  = WR_DMA_ERR_I;
        lat_set[`MCCS_S_RD_DONE] = RD_DMA_DONE_I;
        lat_set[`MCCS_S_WR_DONE] = WR_DMA_DONE_I;
        // Received status latches regardless of the interrupt enable
        lat_set[`MCCS_S_PKT]     = PKT_RCVD_I;
        lat_clr = wr_stat ? (REG_WDATA_I & `MCCS_STAT_W1C) : `MCCS_ZERO32;
        // A new event in the clearing cycle survives
        nxt_lat = ((lat_ff & ~lat_clr) | lat_set) & `MCCS_STAT_W1C;
    end

    always @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            lat_ff <= `MCCS_STAT_RST;
        end else begin
            lat_ff <= nxt_lat;
        end
    end

    // ------------------------------------------------------------------
    // Packet-length validity
    // ------------------------------------------------------------------
    always @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            pkt_valid_ff <= 1'b0;
        end else begin
            pkt_valid_ff <= ~PLEN_FIFO_EMPTY_I;
        end
    end

    mccs_plen u_plen (
        .clk_i        (MCLK_I),
        .rst_b_i      (RST_B_I),
        .valid_only_i (ctrl_ff[`MCCS_C_VLO]),
        .rd_i         (PLEN_RD_I & ~ctrl_ff[`MCCS_C_PKT_DIS]),
        .fifo_data_i  (PLEN_FIFO_DATA_I),
        .fifo_empty_i (PLEN_FIFO_EMPTY_I),
        .fifo_pop_o   (plen_pop),
        .len_o        (PLEN_DATA_O)
    );

    assign PLEN_POP_O = plen_pop;

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    // Level interrupt: drops with the count or the enable
    assign irq_nondma =
        (ctrl_ff[`MCCS_C_PCG_IE] & pcg_flag)
      | (ctrl_ff[`MCCS_C_PKT_IE] & lat_ff[`MCCS_S_PKT])
      | (ctrl_ff[`MCCS_C_AF_IE]  & rx_af_now)
      | ctrl_ff[`MCCS_C_FORCE];
    // Receive-error enable is deliberately absent above
    assign irq_dma = ctrl_ff[`MCCS_C_DMA_IE]
                   & (lat_ff[`MCCS_S_RD_DONE] | lat_ff[`MCCS_S_WR_DONE]);

    assign IRQ_O = irq_dma | (ctrl_ff[`MCCS_C_MIE] & irq_nondma);

    // ------------------------------------------------------------------
    // Transmit, loopback and arbitration
    // ------------------------------------------------------------------
    assign tx_data_avail = ~TX_EMPTY_I;
    // Unpacketised data goes out as soon as it is in the FIFO
    assign TX_GO_O  = ctrl_ff[`MCCS_C_PKT_DIS] ? tx_data_avail
                    : (tx_data_avail & TX_LEN_AVAIL_I);
    assign EOP_EN_O = ~ctrl_ff[`MCCS_C_PKT_DIS];

    always @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            lb_wr_ff   <= 1'b0;
            lb_data_ff <= `MCCS_ZERO32;
        end else begin
            lb_wr_ff <= TX_WR_I & ctrl_ff[`MCCS_C_LOOP];
            if (TX_WR_I) begin
                lb_data_ff <= TX_WDATA_I;
            end
        end
    end

    assign RX_LB_WR_O    = lb_wr_ff;
    assign RX_LB_WDATA_O = lb_data_ff;
    // Only meaningful while a FIFO reset is held by software
    assign LVL_ACCESS_O  = ctrl_ff[`MCCS_C_LVL_LD];

    assign DMA_PRIO_REQ_O = ctrl_ff[`MCCS_C_ARB_PRI] & (tx_ae_now | rx_af_now);

    // ------------------------------------------------------------------
    // Resets
    // ------------------------------------------------------------------
    assign TX_RST_O      = ctrl_ff[`MCCS_C_TX_RST];
    assign RX_RST_O      = ctrl_ff[`MCCS_C_RX_RST];
    assign DDR_CNT_CLR_O = TX_RST_O | RX_RST_O;
    // Link tracking survives resets while monitoring runs
    assign PROT_RST_O    = DDR_CNT_CLR_O & ~link_en;

    // ------------------------------------------------------------------
    // Link
    // ------------------------------------------------------------------
    assign link_en = (MON_MODE_I != `MCCS_MON_OFF);

    mccs_link_fsm u_link (
        .clk_i     (MCLK_I),
        .rst_b_i   (RST_B_I),
        .enable_i  (link_en & ~PROT_RST_O),
        .start_i   (ctrl_ff[`MCCS_C_START]),
        .auto_i    (ctrl_ff[`MCCS_C_AUTO]),
        .null_rx_i (NULL_RX_I),
        .fct_rx_i  (FCT_RX_I),
        .err_i     (LINK_ERR_I),
        .started_o (LINK_STARTED_O),
        .run_o     (link_run)
    );

    // ------------------------------------------------------------------
    // Status word assembly
    // ------------------------------------------------------------------
    always @* begin
        stat_word = lat_ff;
        stat_word[`MCCS_S_TC_HI:`MCCS_S_TC_LO] = TIME_CODE_I;
        stat_word[`MCCS_S_IRQ]  = irq_nondma;
        stat_word[`MCCS_S_PLV]  = pkt_valid_ff;
        stat_word[`MCCS_S_LINK] = link_run;
        stat_word[`MCCS_S_PCG]  = pcg_flag;
        stat_word[`MCCS_S_ERR_HI:`MCCS_S_ERR_LO] = 6'h00;
        stat_word[`MCCS_S_RDV]    = RX_DATA_VALID_I;
        stat_word[`MCCS_S_RXF]    = RX_FULL_I;
        stat_word[`MCCS_S_RXAF]   = rx_af_now;
        stat_word[`MCCS_S_RXE]    = RX_EMPTY_I;
        stat_word[`MCCS_S_TXE_HI] = TX_EMPTY_I;
        stat_word[`MCCS_S_TXF]    = TX_FULL_I;
        stat_word[`MCCS_S_TXAE]   = tx_ae_now;
        stat_word[`MCCS_S_TXE]    = TX_EMPTY_I;
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always @* begin
        nxt_rdata = `MCCS_ZERO32;
        if (hit(REG_ADDR_I, `MCCS_OFS_CTRL)) begin
            nxt_rdata = ctrl_ff;
            nxt_rdata[`MCCS_C_DMA_RDY] = ~RD_DMA_BUSY_I;
            nxt_rdata[`MCCS_C_TCF_HI:`MCCS_C_TCF_LO] = 2'h0;
        end else if (hit(REG_ADDR_I, `MCCS_OFS_STAT)) begin
            nxt_rdata = stat_word;
        end
    end

    always @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rdata_ff <= `MCCS_ZERO32;
        end else if (REG_RD_I) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign REG_RDATA_O = rdata_ff;
endmodule

// ===== verif/mccs_far_node.sv
// Far link node model: sends Null then FCT characters
`timescale 1ns/100ps
module mccs_far_node (
    // Clock and reset
    input  wire clk_i,
    input  wire rst_b_i,
    // Monitor state and bench request
    input  wire started_i,
    input  wire beckon_i,
    // Characters toward the monitor
    output reg  null_o,
    output reg  fct_o
);
    reg [1:0] gap_ff;
    reg       seen_ff;
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            gap_ff <= 2'h0;
            seen_ff <= 1'b0;
            null_o <= 1'b0;
            fct_o <= 1'b0;
        end else begin
            gap_ff <= gap_ff + 2'h1;
            // Nulls while trying to connect
            null_o <= (beckon_i || started_i) && gap_ff == 2'h0;
            // FCT only after a Null, never into a fresh Started state
            seen_ff <= started_i && (seen_ff || null_o);
            fct_o <= seen_ff && gap_ff == 2'h2;
        end
    end
endmodule

// ===== verif/mccs_top_properties.sv
// Concurrent checks on the channel control/status ports
`timescale 1ns/100ps
module mccs_top_properties (
    // Clock, reset and register port
    input wire        MCLK_I,
    input wire        RST_B_I,
    input wire [7:0]  REG_ADDR_I,
    input wire        REG_WR_I,
    input wire        REG_RD_I,
    input wire [31:0] REG_WDATA_I,
    input wire [31:0] REG_RDATA_O,
    // DMA and levels
    input wire        RD_DMA_BUSY_I,
    input wire        DMA_PRIO_REQ_O,
    input wire [15:0] RX_LEVEL_I,
    input wire [15:0] RX_AFL_I,
    input wire [15:0] TX_LEVEL_I,
    input wire [15:0] TX_AEL_I,
    // Packet length and transmit path
    input wire        PLEN_RD_I,
    input wire        PLEN_FIFO_EMPTY_I,
    input wire        PLEN_POP_O,
    input wire        TX_WR_I,
    input wire [31:0] TX_WDATA_I,
    input wire        EOP_EN_O,
    input wire        RX_LB_WR_O,
    input wire [31:0] RX_LB_WDATA_O,
    input wire        LVL_ACCESS_O,
    // Resets
    input wire [1:0]  MON_MODE_I,
    input wire        TX_RST_O,
    input wire        RX_RST_O,
    input wire        DDR_CNT_CLR_O,
    input wire        PROT_RST_O
);
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RST_B_I);

    AST_CTRL_WR: assert property (REG_WR_I && REG_ADDR_I == 8'h00 |=>
        LVL_ACCESS_O == $past(REG_WDATA_I[23]) && TX_RST_O == $past(REG_WDATA_I[4])
        && RX_RST_O == $past(REG_WDATA_I[5]) && EOP_EN_O == !$past(REG_WDATA_I[10]))
        else $error("control write not reflected");
    AST_RST_CLR: assert property (!$past(RST_B_I) |-> !TX_RST_O && !RX_RST_O
        && !LVL_ACCESS_O && EOP_EN_O && !RX_LB_WR_O) else $error("control not cleared");
    AST_RD_CTRL: assert property (REG_RD_I && REG_ADDR_I == 8'h00 |=>
        REG_RDATA_O[31] == !$past(RD_DMA_BUSY_I) && REG_RDATA_O[29:28] == 2'h0)
        else $error("control read-only bits wrong");
    AST_RD_ERR: assert property (REG_RD_I && REG_ADDR_I == 8'h04 |=>
        REG_RDATA_O[13:8] == 6'h00) else $error("error flags not zero");
    AST_PRIO: assert property (DMA_PRIO_REQ_O |->
        TX_LEVEL_I < TX_AEL_I || RX_LEVEL_I >= RX_AFL_I) else $error("priority without cause");
    AST_POP: assert property (PLEN_POP_O ==
        (PLEN_RD_I && !PLEN_FIFO_EMPTY_I && EOP_EN_O)) else $error("length pop wrong");
    AST_LB: assert property (RX_LB_WR_O |-> $past(TX_WR_I)
        && RX_LB_WDATA_O == $past(TX_WDATA_I)) else $error("loopback copy wrong");
    AST_PROT: assert property (PROT_RST_O |-> (TX_RST_O || RX_RST_O)
        && MON_MODE_I == 2'h0) else $error("protected reset while monitoring");
    AST_DDR: assert property (DDR_CNT_CLR_O == (TX_RST_O || RX_RST_O))
        else $error("count clear wrong");

    cover property (RX_LB_WR_O);
    cover property (PROT_RST_O);
    cover property (PLEN_POP_O);
    cover property (DMA_PRIO_REQ_O);
endmodule

// ===== verif/tb_mccs_top.sv
// Testbench for the channel control/status block
`timescale 1ns/100ps
module tb_mccs_top;
    reg         mclk, rst_b, reg_wr, reg_rd, busy, plen_mt, len_av, lnk_err, beckon;
    reg  [6:0]  pls;
    reg  [4:0]  flg;
    reg  [7:0]  addr;
    reg  [1:0]  mon;
    reg  [5:0]  tcode;
    reg  [15:0] rx_lvl, cnt;
    reg  [31:0] wdata, plen_d, tx_d, got;
    wire [31:0] rdata, plen_o, lb_d;
    wire        prio, pop, go, eop, lb_wr, lvl, started;
    wire        txr, rxr, ddr, prot, irq, null_rx, fct_rx;
    integer     n_fail, samples_checked, i;

    mccs_top uut (.MCLK_I(mclk), .RST_B_I(rst_b), .REG_ADDR_I(addr), .REG_WR_I(reg_wr),
        .REG_RD_I(reg_rd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
        .RD_DMA_BUSY_I(busy), .RD_DMA_DONE_I(pls[1]), .WR_DMA_DONE_I(pls[0]),
        .RD_DMA_ERR_I(pls[3]), .WR_DMA_ERR_I(pls[2]), .DMA_PRIO_REQ_O(prio),
        .RX_LEVEL_I(rx_lvl), .RX_AFL_I(16'h0010), .TX_LEVEL_I(16'h0000),
        .TX_AEL_I({15'h0, len_av}), .RX_DATA_VALID_I(flg[4]), .RX_FULL_I(flg[3]),
        .RX_EMPTY_I(flg[2]), .TX_FULL_I(flg[1]), .TX_EMPTY_I(flg[0]),
        .PKT_RCVD_I(pls[4]), .PKT_CNT_I(cnt), .PKT_THR_I(16'h0005), .PLEN_RD_I(pls[6]),
        .PLEN_FIFO_DATA_I(plen_d), .PLEN_FIFO_EMPTY_I(plen_mt), .PLEN_POP_O(pop),
        .PLEN_DATA_O(plen_o), .TX_WR_I(pls[5]), .TX_WDATA_I(tx_d), .TX_LEN_AVAIL_I(len_av),
        .TX_GO_O(go), .EOP_EN_O(eop), .RX_LB_WR_O(lb_wr), .RX_LB_WDATA_O(lb_d),
        .LVL_ACCESS_O(lvl), .MON_MODE_I(mon), .NULL_RX_I(null_rx), .FCT_RX_I(fct_rx),
        .LINK_ERR_I(lnk_err), .TIME_CODE_I(tcode), .LINK_STARTED_O(started),
        .TX_RST_O(txr), .RX_RST_O(rxr), .DDR_CNT_CLR_O(ddr), .PROT_RST_O(prot), .IRQ_O(irq));

    mccs_far_node u_far (.clk_i(mclk), .rst_b_i(rst_b), .started_i(started),
        .beckon_i(beckon), .null_o(null_rx), .fct_o(fct_rx));

    always #50 mclk = ~mclk;

    // ------------------------------------------------------------
    // Access and checking tasks
    // ------------------------------------------------------------
    task give_verdict;
        begin
            if (n_fail == 0 && samples_checked > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task ck(input [31:0] seen, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task tick(input integer n);
        begin
            repeat (n) @(posedge mclk);
            #1;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            tick(1);
            {addr, wdata, reg_wr} = {a, d, 1'b1};
            tick(1);
            reg_wr = 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            tick(1);
            {addr, reg_rd} = {a, 1'b1};
            tick(1);
            reg_rd = 1'b0;
            got = rdata;
        end
    endtask
    task rdc(input [7:0] a, input [31:0] exp);
        begin
            rd(a);
            ck(got, exp);
        end
    endtask
    task pulse(input [6:0] p);
        begin
            tick(1);
            pls = p;
            tick(1);
            pls = 7'h00;
        end
    endtask
    task plen(input ep, input [31:0] el);
        begin
            tick(1);
            pls = 7'h40;
            #1;
            ck(pop, ep);
            tick(1);
            pls = 7'h00;
            ck(plen_o, el);
        end
    endtask
    task wait_run;
        integer k;
        begin
            k = 0;
            got = 32'h0;
            while (got[20] !== 1'b1 && k < 40) begin
                rd(8'h04);
                k = k + 1;
            end
            if (got[20] !== 1'b1) begin
                n_fail = n_fail + 1;
                give_verdict;
            end
        end
    endtask

    initial begin
        {mclk, rst_b, reg_wr, reg_rd, busy, len_av, lnk_err, beckon} = 8'h08;
        {pls, addr, mon, cnt, rx_lvl, wdata, tx_d} = 0;
        {plen_mt, flg, tcode, plen_d} = {1'b1, 5'h15, 6'h2a, 32'h0000_0123};
        {n_fail, samples_checked} = 0;
        repeat (3) @(posedge mclk);
        #1;
        rst_b = 1'b1;
        rdc(8'h00, 32'h0000_0000);
        busy = 1'b0;
        rdc(8'h00, 32'h8000_0000);
        rdc(8'h04, 32'h2a00_0099);
        wr(8'h00, 32'hffff_ffff);
        rdc(8'h00, 32'h86ab_77f0);
        ck(irq, 1);
        ck({lvl, txr, rxr, eop}, 4'he);
        wr(8'h08, 32'hffff_ffff);
        rdc(8'h08, 32'h0);
        wr(8'h00, 32'h0002_0000);
        ck(irq, 0);
        wr(8'h00, 32'h0000_0030);
        ck(prot, 1);
        mon = 2'h1;
        tick(1);
        ck(prot, 0);
        wr(8'h00, 32'h0001_4000);
        pulse(7'h10);
        ck(irq, 1);
        rdc(8'h04, 32'h2a80_4099);
        wr(8'h04, 32'h0000_4000);
        ck(irq, 0);
        wr(8'h00, 32'h0000_4000);
        pulse(7'h10);
        ck(irq, 0);
        rdc(8'h04, 32'h2a80_4099);
        wr(8'h04, 32'h0000_4000);
        wr(8'h00, 32'h0008_0000);
        for (i = 0; i < 4; i = i + 1) begin
            pulse(7'h01 << i);
            ck(irq, i < 2);
            rdc(8'h04, 32'h2a00_0099 | (32'h1 << (16 + i)));
            wr(8'h04, 32'h1 << (16 + i));
        end
        rdc(8'h04, 32'h2a00_0099);
        wr(8'h00, 32'h0401_0000);
        for (i = 0; i < 3; i = i + 1) begin
            cnt = 16'h0005 + (i == 1);
            tick(1);
            ck(irq, i == 1);
        end
        cnt = 16'h0006;
        rdc(8'h04, 32'h2a80_8099);
        cnt = 16'h0000;
        wr(8'h00, 32'h0001_1000);
        for (i = 0; i < 2; i = i + 1) begin
            rx_lvl = 16'h000f + i;
            tick(1);
            ck(irq, i);
        end
        rx_lvl = 16'h0011;
        tick(1);
        rx_lvl = 16'h0000;
        rdc(8'h04, 32'haa00_0099);
        wr(8'h04, 32'h8000_0000);
        rdc(8'h04, 32'h2a00_0099);
        wr(8'h00, 32'h0020_0000);
        rx_lvl = 16'h0010;
        tick(1);
        ck(prio, 1);
        wr(8'h00, 32'h0000_0000);
        ck(prio, 0);
        rx_lvl = 16'h0000;
        wr(8'h00, 32'h0001_2000);
        ck(irq, 0);
        wr(8'h00, 32'h0000_0000);
        plen_mt = 1'b0;
        plen(1, 32'h0000_0123);
        plen_mt = 1'b1;
        plen(0, 32'h0000_0123);
        wr(8'h00, 32'h0200_0000);
        plen(0, 32'h0);
        plen_mt = 1'b0;
        wr(8'h00, 32'h0000_0400);
        plen(0, 32'h0);
        ck(eop, 0);
        flg = 5'h00;
        for (i = 0; i < 4; i = i + 1) begin
            wr(8'h00, i[1] ? 32'h0000_0400 : 32'h0);
            len_av = i[0];
            tick(1);
            ck(go, i[1] | i[0]);
        end
        wr(8'h00, 32'h0000_0040);
        tx_d = 32'ha5a5_5a5a;
        pulse(7'h20);
        ck(lb_wr, 1);
        ck(lb_d, 32'ha5a5_5a5a);
        wr(8'h00, 32'h0000_0000);
        pulse(7'h20);
        ck(lb_wr, 0);
        wr(8'h00, 32'h0000_0200);
        tick(12);
        ck(started, 0);
        beckon = 1'b1;
        wait_run;
        ck(started, 1);
        wr(8'h00, 32'h0000_0080);
        rdc(8'h00, 32'h8000_0080);
        ck(started, 1);
        lnk_err = 1'b1;
        tick(1);
        lnk_err = 1'b0;
        tick(12);
        ck(started, 0);
        beckon = 1'b0;
        wr(8'h00, 32'h0000_0100);
        wait_run;
        ck(started, 1);
        rdc(8'h04, 32'h6a50_0002);
        give_verdict;
    end
endmodule

bind mccs_top mccs_top_properties u_props (.MCLK_I(MCLK_I), .RST_B_I(RST_B_I),
    .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .RD_DMA_BUSY_I(RD_DMA_BUSY_I),
    .DMA_PRIO_REQ_O(DMA_PRIO_REQ_O), .RX_LEVEL_I(RX_LEVEL_I), .RX_AFL_I(RX_AFL_I),
    .TX_LEVEL_I(TX_LEVEL_I), .TX_AEL_I(TX_AEL_I), .PLEN_RD_I(PLEN_RD_I),
    .PLEN_FIFO_EMPTY_I(PLEN_FIFO_EMPTY_I), .PLEN_POP_O(PLEN_POP_O), .TX_WR_I(TX_WR_I),
    .TX_WDATA_I(TX_WDATA_I), .EOP_EN_O(EOP_EN_O), .RX_LB_WR_O(RX_LB_WR_O),
    .RX_LB_WDATA_O(RX_LB_WDATA_O), .LVL_ACCESS_O(LVL_ACCESS_O), .MON_MODE_I(MON_MODE_I),
    .TX_RST_O(TX_RST_O), .RX_RST_O(RX_RST_O), .DDR_CNT_CLR_O(DDR_CNT_CLR_O),
    .PROT_RST_O(PROT_RST_O));
